// ---- spc_pkg.sv ----
// Constants shared by the master SPI serial port control block.
// Assumes one 32-bit AHB-Lite slave port, byte offsets in the low bits.
`default_nettype none
package spc_pkg;
  // ==========================================================
  // Register map (byte offsets)
  localparam int          ADDR_W     = 8;
  localparam logic [7:0]  ADDR_DATA  = 8'h00;
  localparam logic [7:0]  ADDR_STAT  = 8'h04;
  localparam logic [7:0]  ADDR_CTRLB = 8'h08;
  localparam logic [7:0]  ADDR_CTRLC = 8'h0C;
  localparam logic [7:0]  ADDR_BAUD  = 8'h10;
  // ==========================================================
  // Field positions
  localparam int          S_RXC      = 7;
  localparam int          S_TXC      = 6;
  localparam int          S_UDRE     = 5;
  localparam int          B_IE_LO    = 5;
  localparam int          B_RXEN     = 4;
  localparam int          B_TXEN     = 3;
  localparam int          C_MODE_LO  = 6;
  localparam int          C_ORDER    = 2;
  localparam int          C_PHASE    = 1;
  localparam int          C_POL      = 0;
  // ==========================================================
  // Reset values and encodings
  localparam logic [7:0]  CTRLB_RST  = 8'h00;
  localparam logic [7:0]  CTRLC_RST  = 8'h06;
  localparam logic [1:0]  MODE_ASYNC = 2'h0;
  localparam logic [1:0]  MODE_SYNC  = 2'h1;
  localparam logic [1:0]  MODE_RSVD  = 2'h2;
  localparam logic [1:0]  MODE_MSPI  = 2'h3;
  // ==========================================================
  // Frame timing and bus transfer type
  localparam int          DATA_W     = 8;
  localparam int          BAUD_W     = 12;
  localparam logic [3:0]  LAST_EDGE  = 4'hF;
  localparam logic [3:0]  FIRST_EDGE = 4'h0;
  localparam logic [1:0]  HTRANS_NSQ = 2'h2;
endpackage : spc_pkg
`default_nettype wire

// ---- spc_fifo_if.sv ----
// Interface carrying the receive buffer handshake.
// Assumes the engine is the source and the buffer the sink.
`timescale 1ns/1ns
`default_nettype none
interface spc_fifo_if #(parameter int W = 8);
  logic         wr_valid;
  logic         wr_ready;
  logic [W-1:0] wr_data;
  logic         rd_valid;
  logic         rd_ready;
  logic [W-1:0] rd_data;
  logic         flush;
  // ==========================================================
  // Engine side and buffer side
  modport src  (output wr_valid, wr_data, rd_ready, flush,
                input  wr_ready, rd_valid, rd_data);
  modport sink (input  wr_valid, wr_data, rd_ready, flush,
                output wr_ready, rd_valid, rd_data);
endinterface : spc_fifo_if
`default_nettype wire

// ---- spc_sync2.sv ----
// Two flip-flop synchroniser for one level.
// Assumes the input is asynchronous to clk.
`timescale 1ns/1ns
`default_nettype none
module spc_sync2 (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic d,
  output logic      q
);
  logic meta_q;
  // ==========================================================
  // Two stages; only the second stage reads the first
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= 1'h0;
      q      <= 1'h0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule : spc_sync2
`default_nettype wire

// ---- spc_fifo.sv ----
// Receive buffer: flip-flop FIFO with valid/ready and flush.
// Assumes DEPTH is a power of two.
`timescale 1ns/1ns
`default_nettype none
module spc_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  input  wire logic clk,
  input  wire logic rst,
  spc_fifo_if.sink  f
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0]  mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0]   cnt_q;
  logic          push;
  logic          pop;
  // ==========================================================
  // Handshake
  assign f.wr_ready = (cnt_q != (AW+1)'(DEPTH));
  assign f.rd_valid = (cnt_q != '0) && !f.flush;  // Flushed entries vanish at once
  assign f.rd_data  = mem_q[rp_q];
  assign push       = f.wr_valid && f.wr_ready && !f.flush;
  assign pop        = f.rd_ready && f.rd_valid && !f.flush;
  // Pointers and fill level; flush empties at once
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else if (f.flush) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wp_q <= wp_q + 1'h1;
      if (pop) rp_q <= rp_q + 1'h1;
      if (push && !pop) cnt_q <= cnt_q + 1'h1;
      else if (pop && !push) cnt_q <= cnt_q - 1'h1;
    end
  end
  // ==========================================================
  // Storage, one flop word per entry
  for (genvar i = 0; i < DEPTH; i++) begin : g_ent
    always_ff @(posedge clk or posedge rst) begin
      if (rst) mem_q[i] <= '0;
      else if (push && wp_q == AW'(i)) mem_q[i] <= f.wr_data;
    end
  end
endmodule : spc_fifo
`default_nettype wire

// ---- spc_top.sv ----
// Master-only SPI engine of a serial port, with its control registers.
// Assumes an AHB-Lite master on ref_clk and an SPI slave on the pins.
`timescale 1ns/1ns
`default_nettype none
module spc_top #(
  parameter int FIFO_DEPTH = 16
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        serial_in_pin,
  output logic             serial_out_pin,
  output logic             serial_out_oe,
  output logic             serial_clock_pin,
  output logic             serial_clock_oe,
  output logic             rx_pin_owned
);
  typedef enum logic {ST_IDLE, ST_SHIFT} spc_state_t;

  // ==========================================================
  // Declarations
  logic                       acc;
  logic                       rd_acc;
  logic                       wr_pend_q;
  logic [spc_pkg::ADDR_W-1:0] waddr_q;
  logic [7:0]                 wdat;
  logic                       w_data;
  logic                       w_stat;
  logic                       w_b;
  logic                       w_c;
  logic [31:0]                rd_word;
  logic [31:0]                hrdata_q;
  logic [2:0]                 ie_q;
  logic                       rx_en_q;
  logic                       tx_req_q;
  logic                       tx_act_q;
  logic [1:0]                 mode_q;
  logic                       order_q;
  logic                       cpha_q;
  logic                       cpol_q;
  logic [spc_pkg::BAUD_W-1:0] baud_q;
  logic                       mspi;
  logic [7:0]                 txbuf_q;
  logic                       txbuf_full_q;
  logic                       txc_q;
  spc_state_t                 st_q;
  logic [spc_pkg::BAUD_W-1:0] div_q;
  logic [3:0]                 edge_q;
  logic                       tick;
  logic                       start;
  logic                       samp;
  logic                       adv;
  logic                       done_q;
  logic                       sck_q;
  logic                       sdo_q;
  logic [7:0]                 txsh_q;
  logic [7:0]                 rxsh_q;
  logic                       sin_s;

  spc_fifo_if #(.W(spc_pkg::DATA_W)) fif ();

  // ==========================================================
  // Bus slave: zero wait states, always OKAY
  assign hreadyout = 1'h1;
  assign hresp     = 1'h0;
  assign hrdata    = hrdata_q;
  assign acc       = hsel && (htrans == spc_pkg::HTRANS_NSQ) && hready;
  assign rd_acc    = acc && !hwrite;

  // Address phase of a write, applied in its data phase
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wr_pend_q <= 1'h0;
      waddr_q   <= '0;
    end else begin
      wr_pend_q <= acc && hwrite;
      if (acc) waddr_q <= haddr[spc_pkg::ADDR_W-1:0];
    end
  end

  // Write strobes
  assign wdat   = hwdata[7:0];
  assign w_data = wr_pend_q && (waddr_q == spc_pkg::ADDR_DATA);
  assign w_stat = wr_pend_q && (waddr_q == spc_pkg::ADDR_STAT);
  assign w_b    = wr_pend_q && (waddr_q == spc_pkg::ADDR_CTRLB);
  assign w_c    = wr_pend_q && (waddr_q == spc_pkg::ADDR_CTRLC);

  // Read multiplexer, unmapped offsets read zero
  always_comb begin
    rd_word = '0;
    if (haddr[spc_pkg::ADDR_W-1:0] == spc_pkg::ADDR_DATA) begin
      rd_word[7:0] = fif.rd_data;
    end else if (haddr[spc_pkg::ADDR_W-1:0] == spc_pkg::ADDR_STAT) begin
      rd_word[spc_pkg::S_RXC]  = fif.rd_valid;
      rd_word[spc_pkg::S_TXC]  = txc_q;
      rd_word[spc_pkg::S_UDRE] = !txbuf_full_q;
      // Error flags stay zero in this mode
    end else if (haddr[spc_pkg::ADDR_W-1:0] == spc_pkg::ADDR_CTRLB) begin
      rd_word[7:spc_pkg::B_IE_LO] = ie_q;
      rd_word[spc_pkg::B_RXEN]    = rx_en_q;
      rd_word[spc_pkg::B_TXEN]    = tx_req_q;
    end else if (haddr[spc_pkg::ADDR_W-1:0] == spc_pkg::ADDR_CTRLC) begin
      rd_word[7:spc_pkg::C_MODE_LO] = mode_q;  // Bits 5:3 read zero
      rd_word[spc_pkg::C_ORDER]     = order_q;
      rd_word[spc_pkg::C_PHASE]     = cpha_q;
      rd_word[spc_pkg::C_POL]       = cpol_q;
    end else if (haddr[spc_pkg::ADDR_W-1:0] == spc_pkg::ADDR_BAUD) begin
      rd_word[spc_pkg::BAUD_W-1:0] = baud_q;
    end
  end

  // Read data captured at the address phase edge
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) hrdata_q <= '0;
    else if (rd_acc) hrdata_q <= rd_word;
  end

  // ==========================================================
  // Control register B; reserved low bits are not stored
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ie_q     <= spc_pkg::CTRLB_RST[7:spc_pkg::B_IE_LO];
      rx_en_q  <= spc_pkg::CTRLB_RST[spc_pkg::B_RXEN];
      tx_req_q <= spc_pkg::CTRLB_RST[spc_pkg::B_TXEN];
    end else if (w_b) begin
      ie_q     <= wdat[7:spc_pkg::B_IE_LO];
      rx_en_q  <= wdat[spc_pkg::B_RXEN];
      tx_req_q <= wdat[spc_pkg::B_TXEN];
    end
  end

  // Effective transmitter enable: on at once, off only when drained
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tx_act_q <= spc_pkg::CTRLB_RST[spc_pkg::B_TXEN];
    end else if (w_b && wdat[spc_pkg::B_TXEN]) begin
      tx_act_q <= 1'h1;
    end else if (!tx_req_q && st_q == ST_IDLE && !txbuf_full_q) begin
      tx_act_q <= 1'h0;
    end
  end

  // Control register C: mode and frame shape in one write
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mode_q  <= spc_pkg::CTRLC_RST[7:spc_pkg::C_MODE_LO];
      order_q <= spc_pkg::CTRLC_RST[spc_pkg::C_ORDER];
      cpha_q  <= spc_pkg::CTRLC_RST[spc_pkg::C_PHASE];
      cpol_q  <= spc_pkg::CTRLC_RST[spc_pkg::C_POL];
    end else if (w_c) begin
      mode_q  <= wdat[7:spc_pkg::C_MODE_LO];
      order_q <= wdat[spc_pkg::C_ORDER];
      cpha_q  <= wdat[spc_pkg::C_PHASE];
      cpol_q  <= wdat[spc_pkg::C_POL];
    end
  end

  // Baud register: half clock period is baud_q plus one cycles
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) baud_q <= '0;
    else if (wr_pend_q && waddr_q == spc_pkg::ADDR_BAUD) baud_q <= hwdata[spc_pkg::BAUD_W-1:0];
  end

  assign mspi = (mode_q == spc_pkg::MODE_MSPI);

  // ==========================================================
  // Transmit buffer; a write while full or disabled is dropped
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      txbuf_q      <= '0;
      txbuf_full_q <= 1'h0;
    end else if (w_data && !txbuf_full_q && tx_act_q) begin
      txbuf_q      <= wdat;
      txbuf_full_q <= 1'h1;
    end else if (start) begin
      txbuf_full_q <= 1'h0;
    end
  end

  // Transmit complete: set wins over a write-one clear
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) txc_q <= 1'h0;
    else if (done_q && !txbuf_full_q) txc_q <= 1'h1;
    else if (w_stat && wdat[spc_pkg::S_TXC]) txc_q <= 1'h0;
  end

  // ==========================================================
  // Shift engine
  // Only the transmitter starts frames; a full receive buffer stalls
  assign start = (st_q == ST_IDLE) && txbuf_full_q && mspi && tx_act_q
                 && (!rx_en_q || fif.wr_ready);
  assign tick  = (st_q == ST_SHIFT) && (div_q == '0);
  // Even edges lead, odd edges trail; phase picks the sample edge
  assign samp  = tick && (edge_q[0] == cpha_q);
  assign adv   = tick && (edge_q[0] != cpha_q) && (edge_q != spc_pkg::LAST_EDGE)
                 && !(cpha_q && edge_q == spc_pkg::FIRST_EDGE);

  // Frame state, half-period divider and edge counter
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_q   <= ST_IDLE;
      div_q  <= '0;
      edge_q <= '0;
      done_q <= 1'h0;
    end else begin
      done_q <= 1'h0;
      case (st_q)
        ST_IDLE: begin
          if (start) begin
            st_q   <= ST_SHIFT;
            div_q  <= baud_q;
            edge_q <= '0;
          end
        end
        ST_SHIFT: begin
          if (!mspi) begin
            st_q <= ST_IDLE;
          end else if (tick) begin
            div_q <= baud_q;
            if (edge_q == spc_pkg::LAST_EDGE) begin
              st_q   <= ST_IDLE;
              done_q <= 1'h1;
            end else begin
              edge_q <= edge_q + 4'h1;
            end
          end else begin
            div_q <= div_q - 1'h1;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // Serial clock: idles at the polarity level, toggles each edge
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) sck_q <= 1'h0;
    else if (st_q == ST_IDLE) sck_q <= cpol_q;
    else if (tick) sck_q <= !sck_q;
  end

  // Transmit shifter, loaded from the buffer
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      txsh_q <= '0;
    end else if (start) begin
      txsh_q <= txbuf_q;
    end else if (adv) begin
      if (order_q) txsh_q <= {1'h0, txsh_q[7:1]};
      else txsh_q <= {txsh_q[6:0], 1'h0};
    end
  end

  // Data-out bit from the selected end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) sdo_q <= 1'h0;
    else sdo_q <= order_q ? txsh_q[0] : txsh_q[7];
  end

  // Receive shifter fills in the same bit order
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rxsh_q <= '0;
    end else if (samp) begin
      if (order_q) rxsh_q <= {sin_s, rxsh_q[7:1]};
      else rxsh_q <= {rxsh_q[6:0], sin_s};
    end
  end

  // Data-in pin resynchronised before use
  spc_sync2 u_sin (
    .clk (ref_clk),
    .rst (rst),
    .d   (serial_in_pin),
    .q   (sin_s)
  );

  // ==========================================================
  // Receive buffer
  assign fif.wr_valid = done_q && rx_en_q;
  assign fif.wr_data  = rxsh_q;
  assign fif.rd_ready = rd_acc && (haddr[spc_pkg::ADDR_W-1:0] == spc_pkg::ADDR_DATA);
  assign fif.flush    = !rx_en_q;

  spc_fifo #(
    .W     (spc_pkg::DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk (ref_clk),
    .rst (rst),
    .f   (fif.sink)
  );

  // ==========================================================
  // Pin ownership
  assign serial_clock_pin = sck_q;
  assign serial_out_pin   = sdo_q;
  assign serial_clock_oe  = tx_act_q && mspi;
  assign serial_out_oe    = tx_act_q && mspi;
  assign rx_pin_owned     = rx_en_q && mspi;
endmodule : spc_top
`default_nettype wire

// ---- spc_monitor.sv ----
// Assertion checker for the master SPI serial port control block.
// Assumes it is bound to spc_top and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module spc_monitor (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        serial_out_oe,
  input wire logic        serial_clock_pin,
  input wire logic        serial_clock_oe,
  input wire logic        rx_pin_owned
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic       ap_q;
  logic       wr_q;
  logic [7:0] adr_q;
  logic [7:0] ctlb_q;
  logic [7:0] ctlc_q;
  // ==========
  // Bus phase tracking
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ap_q  <= 1'b0;
      wr_q  <= 1'b0;
      adr_q <= 8'h00;
    end else begin
      ap_q  <= hsel && htrans == spc_pkg::HTRANS_NSQ && hready;
      wr_q  <= hwrite;
      adr_q <= haddr[7:0];
    end
  end
  // Shadow copies of both control registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctlb_q <= spc_pkg::CTRLB_RST;
      ctlc_q <= spc_pkg::CTRLC_RST;
    end else if (ap_q && wr_q) begin
      if (adr_q == spc_pkg::ADDR_CTRLB) ctlb_q <= hwdata[7:0];
      if (adr_q == spc_pkg::ADDR_CTRLC) ctlc_q <= hwdata[7:0];
    end
  end
  wire logic mspi  = ctlc_q[7:6] == spc_pkg::MODE_MSPI;
  wire logic tx_on = ctlb_q[spc_pkg::B_TXEN] && mspi;
  wire logic rx_on = ctlb_q[spc_pkg::B_RXEN] && mspi;
  wire logic rd_dp = ap_q && !wr_q;
  // ==========
  // Pin ownership, link timing and register readback
  a_oe_pair: assert property (serial_clock_oe == serial_out_oe)
    else $error("clock and data-out enables differ");
  a_tx_take: assert property ($rose(tx_on) |-> ##[0:1] serial_out_oe)
    else $error("transmitter did not take the data-out pin");
  a_tx_mode: assert property (serial_out_oe |-> mspi || $past(mspi))
    else $error("data-out driven outside master SPI mode");
  a_tx_release: assert property ($fell(serial_out_oe) |-> !tx_on)
    else $error("data-out released while transmitter requested");
  a_rx_take: assert property ($rose(rx_on) |-> ##[0:1] rx_pin_owned)
    else $error("receiver did not take the data-in pin");
  a_rx_cause: assert property (rx_pin_owned |-> rx_on || $past(rx_on))
    else $error("data-in pin owned without receiver enabled");
  a_clock_quiet: assert property ($changed(serial_clock_pin) |->
    serial_out_oe || $past(serial_out_oe) || $past(ctlc_q[0], 2) != ctlc_q[0])
    else $error("serial clock moved with transmitter off");
  a_edge_gap: assert property ($changed(serial_clock_pin) && serial_out_oe |=>
    $stable(serial_clock_pin)[*3])
    else $error("serial clock edges too close");
  a_rsvd_b: assert property (rd_dp && adr_q == spc_pkg::ADDR_CTRLB |-> hrdata[2:0] == 3'h0)
    else $error("control B reserved bits not zero");
  a_ctrlc_read: assert property (rd_dp && adr_q == spc_pkg::ADDR_CTRLC |->
    hrdata[7:0] == {ctlc_q[7:6], 3'h0, ctlc_q[2:0]})
    else $error("control C readback wrong");
  a_err_flags: assert property (rd_dp && adr_q == spc_pkg::ADDR_STAT |-> hrdata[4:2] == 3'h0)
    else $error("error flags not zero");
endmodule : spc_monitor
bind spc_top spc_monitor mon_u (.ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .serial_out_oe(serial_out_oe),
  .serial_clock_pin(serial_clock_pin), .serial_clock_oe(serial_clock_oe), .rx_pin_owned(rx_pin_owned));
`default_nettype wire

// ---- spc_slave_model.sv ----
// Behavioural SPI slave standing on the serial pins.
// Assumes the bench selects it around frames and sets its phase and order.
`timescale 1ns/1ns
`default_nettype none
module spc_slave_model (
  input  wire logic       sclk,
  input  wire logic       mosi,
  input  wire logic       sel,
  input  wire logic       cpha,
  input  wire logic       lsb,
  input  wire logic [7:0] reply,
  output logic            miso,
  output logic [7:0]      got,
  output int              edges
);
  int j;
  // Bit sent in a given slot of the frame
  function automatic logic pick(input logic [7:0] d, input int i);
    return lsb ? d[i] : d[7-i];
  endfunction : pick
  initial begin
    edges = 0;
    got = 8'h00;
    miso = 1'b0;
  end
  // New frame: with phase 0 the first bit stands before the first edge
  always @(posedge sel) begin
    edges = 0;
    if (!cpha) miso = pick(reply, 0);
  end
  // A released line no longer shows the last bit
  always @(negedge sel) miso = ~miso;
  // Sample on one kind of edge, shift on the other
  always @(sclk) begin
    if (sel) begin
      j = cpha ? (edges % 16) / 2 : (edges % 16 + 1) / 2;
      if ((edges % 2) == int'(cpha)) got = lsb ? {mosi, got[7:1]} : {got[6:0], mosi};
      else if (j < 8) miso = pick(reply, j);
      else miso = ~miso;
      edges = edges + 1;
    end
  end
endmodule : spc_slave_model
`default_nettype wire

// ---- tb.sv ----
// Self-checking bench for the master SPI serial port control block.
// Assumes the slave model and a single-slave AHB-Lite bus; baud 9 gives an 80 ns link clock.
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd;
  logic        hreadyout, hresp, miso, mosi, mosi_oe, sclk, sclk_oe, rx_own;
  logic        sel = 1'b0;
  logic        cpha = 1'b0;
  logic        lsb = 1'b0;
  logic [7:0]  reply = 8'h00;
  logic [7:0]  got, dv;
  int          edges, n_fail = 0, n_tests = 0, cyc = 0;
  always #2 ref_clk = ~ref_clk;
  spc_top #(.FIFO_DEPTH(16)) dut_u (.ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .serial_in_pin(miso), .serial_out_pin(mosi), .serial_out_oe(mosi_oe),
    .serial_clock_pin(sclk), .serial_clock_oe(sclk_oe), .rx_pin_owned(rx_own));
  spc_slave_model slave_u (.sclk(sclk), .mosi(mosi), .sel(sel), .cpha(cpha), .lsb(lsb), .reply(reply),
    .miso(miso), .got(got), .edges(edges));
  // ==========
  // Verdict, comparison and bus tasks
  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run
  task automatic chk_reg(input string what, input logic [7:0] exp, input logic [7:0] seen);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk_reg
  task automatic chk_pin(input string what, input logic exp, input logic seen);
    chk_reg(what, {7'h0, exp}, {7'h0, seen});
  endtask : chk_pin
  task automatic hold;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
  endtask : hold
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= spc_pkg::HTRANS_NSQ;
    hwrite <= wr;
    hold();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    hold();
    rd = hrdata;
  endtask : bus
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    chk_reg(what, exp, rd[7:0]);
  endtask : rd_chk
  task automatic wait_edges(input int n);
    while (edges != n) @(posedge ref_clk);
    repeat (3) @(posedge ref_clk);
    sel <= 1'b0;
    @(posedge ref_clk);
  endtask : wait_edges
  task automatic xfer(input logic [7:0] d, input logic [7:0] r);
    reply <= r;
    sel <= 1'b1;
    bus(1'b1, spc_pkg::ADDR_DATA, d);
    wait_edges(16);
  endtask : xfer
  // Hang guard
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      complete_run();
    end
  end
  // ==========
  // Test sequence
  initial begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    rd_chk("ctrl_b", spc_pkg::ADDR_CTRLB, spc_pkg::CTRLB_RST);
    rd_chk("ctrl_c", spc_pkg::ADDR_CTRLC, spc_pkg::CTRLC_RST);
    rd_chk("status", spc_pkg::ADDR_STAT, 8'h20);
    rd_chk("unmapped", 8'h1C, 8'h00);
    chk_pin("hresp", 1'b0, hresp);
    bus(1'b1, spc_pkg::ADDR_BAUD, 8'h09);
    bus(1'b1, spc_pkg::ADDR_CTRLB, 8'h18);
    repeat (4) @(posedge ref_clk);
    chk_pin("out_oe async", 1'b0, mosi_oe);
    chk_pin("rx_own async", 1'b0, rx_own);
    bus(1'b1, spc_pkg::ADDR_CTRLB, 8'h10);
    bus(1'b1, spc_pkg::ADDR_CTRLC, 8'hC6);
    repeat (4) @(posedge ref_clk);
    chk_pin("rx_own", 1'b1, rx_own);
    chk_pin("out_oe rx only", 1'b0, mosi_oe);
    sel <= 1'b1;
    bus(1'b1, spc_pkg::ADDR_DATA, 8'h5A);
    repeat (60) @(posedge ref_clk);
    chk_reg("edges rx only", 8'h00, edges[7:0]);
    sel <= 1'b0;
    // Every phase, polarity and order, set in the mode write itself
    for (int m = 0; m < 8; m++) begin
      bus(1'b1, spc_pkg::ADDR_CTRLB, 8'h10);
      bus(1'b1, spc_pkg::ADDR_CTRLC, {m[0] ? spc_pkg::MODE_RSVD : spc_pkg::MODE_SYNC, 6'h06});
      bus(1'b1, spc_pkg::ADDR_CTRLB, 8'h18);
      repeat (3) @(posedge ref_clk);
      chk_pin("out_oe other mode", 1'b0, mosi_oe);
      lsb <= m[2];
      cpha <= m[1];
      bus(1'b1, spc_pkg::ADDR_CTRLC, {5'b11000, m[2:0]});
      repeat (2) @(posedge ref_clk);
      chk_pin("idle clock", m[0], sclk);
      chk_pin("out_oe", 1'b1, mosi_oe);
      dv = 8'h1D + 8'(m * 37);
      xfer(dv, ~dv);
      chk_reg("slave got", dv, got);
      rd_chk("status", spc_pkg::ADDR_STAT, 8'hE0);
      rd_chk("rx data", spc_pkg::ADDR_DATA, ~dv);
      // Clear transmit complete so the next frame must set it again
      bus(1'b1, spc_pkg::ADDR_STAT, 8'h40);
    end
    // Disable requested while one byte is shifting and a second waits in the buffer
    reply <= 8'h3C;
    sel <= 1'b1;
    bus(1'b1, spc_pkg::ADDR_DATA, 8'h81);
    bus(1'b1, spc_pkg::ADDR_DATA, 8'h42);
    bus(1'b1, spc_pkg::ADDR_CTRLB, 8'h10);
    repeat (4) @(posedge ref_clk);
    chk_pin("out_oe held", 1'b1, mosi_oe);
    wait_edges(32);
    chk_reg("second byte", 8'h42, got);
    chk_pin("out_oe released", 1'b0, mosi_oe);
    bus(1'b1, spc_pkg::ADDR_CTRLB, 8'h00);
    rd_chk("status flushed", spc_pkg::ADDR_STAT, 8'h60);
    chk_pin("rx_own off", 1'b0, rx_own);
    // Fill the receive buffer until a frame stalls, then drain it
    bus(1'b1, spc_pkg::ADDR_CTRLB, 8'h18);
    for (int i = 0; i < 16; i++) xfer(i[7:0], 8'hA0 + i[7:0]);
    reply <= 8'hB0;
    sel <= 1'b1;
    bus(1'b1, spc_pkg::ADDR_DATA, 8'h77);
    repeat (100) @(posedge ref_clk);
    chk_reg("edges when full", 8'h00, edges[7:0]);
    for (int i = 0; i < 17; i++) begin
      rd_chk("drained", spc_pkg::ADDR_DATA, (i == 16) ? 8'hB0 : 8'hA0 + i[7:0]);
      if (i == 0) wait_edges(16);
    end
    rd_chk("status empty", spc_pkg::ADDR_STAT, 8'h60);
    complete_run();
  end
endmodule : tb
`default_nettype wire
